//--- rtl/icedbg_core.v
// Added by the designer: the register offsets and the AXI4-Lite register port.
`include "icedbg_regs.vh"
module icedbg_core (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire        cycDone,
  input  wire [15:0] cycAddr,
  input  wire [7:0]  cycData,
  input  wire [7:0]  cycStatus,
  input  wire [3:0]  cycKind,
  input  wire        stackOp,
  input  wire        opcodeFetchState,
  input  wire        userProbe,
  input  wire        swBreak,
  input  wire        xtalClkTick,
  input  wire        userClkTick,
  output wire        emuRun,
  output wire        emuClkTick,
  output wire        hostMemSel,
  output wire        hostIoSel,
  output wire        irq
);
  localparam [1:0] ST_HALT = 2'd0;
  localparam [1:0] ST_RUN  = 2'd1;
  localparam [1:0] ST_STEP = 2'd2;
  localparam [1:0] ST_MSTP = 2'd3;
  localparam integer DEPTH = `ICEDBG_TRACE_DEPTH;

  reg [1:0]  state_q;
  reg [7:0]  cmd_q;
  reg [15:0] memMap_q;
  reg [15:0] inMap_q;
  reg [15:0] outMap_q;
  reg [23:0] bp0_q;
  reg [23:0] bp1_q;
  reg        useUserClk_q;
  reg [31:0] cycCnt_q;
  reg [5:0]  wrPtr_q;
  reg [5:0]  fill_q;
  reg [5:0]  trIdx_q;
  reg [15:0] trAddr_q [0:DEPTH-1];
  reg [15:0] trDs_q   [0:DEPTH-1];
  reg [3:0]  irqSt_q;
  reg [3:0]  irqEn_q;
  reg [1:0]  bpHitLatch_q;
  reg        awHave_q;
  reg        wHave_q;
  reg [7:0]  awAddr_q;
  reg [31:0] wData_q;
  reg [3:0]  wStrb_q;

  wire [1:0] bpHit;
  wire       cmdWrite;
  wire       anyHit;
  wire       doWrite;
  wire       traceOn;
  wire [3:0] irqSet;
  wire [7:0] cmdByte;
  reg  [1:0] state_d;
  reg  [31:0] rd_d;
  reg        rdOk;

  function automatic mapHit;
    input [15:0] map;
    input [3:0]  sel;
    begin
      mapHit = map[sel];
    end
  endfunction

  icedbg_bp_cmp uBp0 (
    .bpValue          (bp0_q),
    .cycAddr          (cycAddr),
    .cycKind          (cycKind),
    .stackOp          (stackOp),
    .opcodeFetchState (opcodeFetchState),
    .userProbe        (userProbe),
    .hit              (bpHit[0])
  );
  icedbg_bp_cmp uBp1 (
    .bpValue          (bp1_q),
    .cycAddr          (cycAddr),
    .cycKind          (cycKind),
    .stackOp          (stackOp),
    .opcodeFetchState (opcodeFetchState),
    .userProbe        (userProbe),
    .hit              (bpHit[1])
  );

  // Region select is combinational so the host can steer the very cycle being decoded.
  assign hostMemSel = (cycKind[0] | cycKind[1]) &
                      mapHit(memMap_q, cycAddr[15:`ICEDBG_SEG_LSB]); // R1 R3
  assign hostIoSel  = (cycKind[2] & mapHit(inMap_q, cycAddr[7:`ICEDBG_GRP_LSB])) |
                      (cycKind[3] & mapHit(outMap_q, cycAddr[7:`ICEDBG_GRP_LSB])); // R2 R3
  assign emuClkTick = useUserClk_q ? userClkTick : xtalClkTick; // R11
  assign emuRun     = (state_q != ST_HALT);

  assign awready  = ~awHave_q;
  assign wready   = ~wHave_q;
  assign arready  = ~rvalid;
  assign doWrite  = awHave_q & wHave_q & ~bvalid;
  assign cmdWrite = doWrite & (awAddr_q == `ICEDBG_CMD_OFS) & wStrb_q[0];
  assign cmdByte  = wData_q[7:0];
  assign anyHit   = cycDone & (|bpHit) & (state_q != ST_HALT);
  assign traceOn  = cycDone & (state_q != ST_HALT); // R14
  assign irqSet   = {swBreak & (state_q == ST_MSTP), cycDone & (state_q == ST_STEP),
                     anyHit & bpHit[1], anyHit & bpHit[0]};
  assign irq      = |(irqSt_q & irqEn_q);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_HALT: begin
        if (cmdWrite && (cmdByte == `ICEDBG_CMD_RUN || cmdByte == `ICEDBG_CMD_CONT)) begin
          state_d = ST_RUN;
        end else if (cmdWrite && cmdByte == `ICEDBG_CMD_STEP) begin
          state_d = ST_STEP;
        end else if (cmdWrite && cmdByte == `ICEDBG_CMD_MSTEP) begin
          state_d = ST_MSTP;
        end
      end
      ST_RUN: begin
        if (anyHit || (cmdWrite && cmdByte == `ICEDBG_CMD_STOP)) begin
          state_d = ST_HALT; // R6
        end
      end
      ST_STEP: begin
        if (cycDone) begin
          state_d = ST_HALT;
        end
      end
      ST_MSTP: begin
        // Hardware hits stop here too, a stricter reading than software breaks alone.
        if (swBreak || anyHit || (cmdWrite && cmdByte == `ICEDBG_CMD_STOP)) begin
          state_d = ST_HALT; // R10
        end
      end
      default: state_d = ST_HALT;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q  <= ST_HALT;
      cycCnt_q <= 32'h0000_0000;
      wrPtr_q  <= 6'h00;
      fill_q   <= 6'h00;
    end else begin
      state_q <= state_d;
      if (cmdWrite && state_q == ST_HALT && cmdByte == `ICEDBG_CMD_RUN) begin
        cycCnt_q <= 32'h0000_0000; // R15
        fill_q   <= 6'h00;
      end else if (state_q != ST_HALT && emuClkTick) begin
        cycCnt_q <= cycCnt_q + 32'h0000_0001; // R8
      end
      if (traceOn) begin
        wrPtr_q <= (wrPtr_q == DEPTH - 1) ? 6'h00 : wrPtr_q + 6'h01; // R14
        if (fill_q != DEPTH) begin
          fill_q <= fill_q + 6'h01;
        end
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : gTrace
      always @(posedge clk) begin
        if (traceOn && wrPtr_q == gi) begin
          trAddr_q[gi] <= cycAddr; // R7 R9
          trDs_q[gi]   <= {cycStatus, cycData}; // R7 R9
        end
      end
    end
  endgenerate

  // Sticky status: a set in the same cycle as a clear wins.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irqSt_q <= 4'h0;
    end else if (doWrite && awAddr_q == `ICEDBG_IRQCLR_OFS && wStrb_q[0]) begin
      irqSt_q <= (irqSt_q & ~wData_q[3:0]) | irqSet;
    end else begin
      irqSt_q <= irqSt_q | irqSet;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awHave_q     <= 1'b0;
      wHave_q      <= 1'b0;
      awAddr_q     <= 8'h00;
      wData_q      <= 32'h0000_0000;
      wStrb_q      <= 4'h0;
      bvalid       <= 1'b0;
      bresp        <= 2'b00;
      cmd_q        <= 8'h00;
      memMap_q     <= 16'h0000;
      inMap_q      <= 16'h0000;
      outMap_q     <= 16'h0000;
      bp0_q        <= 24'h00_0000;
      bp1_q        <= 24'h00_0000;
      useUserClk_q <= 1'b0;
      trIdx_q      <= 6'h00;
      irqEn_q      <= 4'h0;
      bpHitLatch_q <= 2'b00;
    end else begin
      if (anyHit) begin
        bpHitLatch_q <= bpHit;
      end
      if (awvalid && !awHave_q) begin
        awHave_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && !wHave_q) begin
        wHave_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= 2'b00;
        case (awAddr_q)
          `ICEDBG_CMD_OFS:    if (wStrb_q[0]) cmd_q <= wData_q[7:0]; // R13
          `ICEDBG_MEMMAP_OFS: memMap_q <= wData_q[15:0];
          `ICEDBG_INMAP_OFS:  inMap_q  <= wData_q[15:0];
          `ICEDBG_OUTMAP_OFS: outMap_q <= wData_q[15:0];
          `ICEDBG_BP0_OFS:    bp0_q    <= wData_q[23:0];
          `ICEDBG_BP1_OFS:    bp1_q    <= wData_q[23:0];
          `ICEDBG_TRIDX_OFS:  trIdx_q  <= wData_q[5:0];
          `ICEDBG_IRQEN_OFS:  irqEn_q  <= wData_q[3:0];
          `ICEDBG_CFG_OFS:    useUserClk_q <= wData_q[0];
          `ICEDBG_IRQCLR_OFS: bresp <= 2'b00;
          default:            bresp <= 2'b10;
        endcase
      end
    end
  end

  // Trace index 0 is the newest entry, counting back in time.
  // The sum is eight bits wide so that the largest write pointer cannot wrap it.
  wire [7:0] backSum = {2'b00, wrPtr_q} + 8'd87 - {2'b00, trIdx_q};
  wire [7:0] slotW   = (backSum >= 8'd88) ? backSum - 8'd88 :
                       (backSum >= 8'd44) ? backSum - 8'd44 : backSum;
  wire [5:0] rdSlot  = slotW[5:0];

  always @* begin
    rd_d = 32'h0000_0000;
    rdOk = 1'b1;
    case (araddr)
      `ICEDBG_CMD_OFS:    rd_d = {24'h00_0000, cmd_q};
      `ICEDBG_STAT_OFS:   rd_d = {24'h00_0000, fill_q == DEPTH, bpHitLatch_q,
                                  useUserClk_q, 2'b00, state_q}; // R13
      `ICEDBG_MEMMAP_OFS: rd_d = {16'h0000, memMap_q};
      `ICEDBG_INMAP_OFS:  rd_d = {16'h0000, inMap_q};
      `ICEDBG_OUTMAP_OFS: rd_d = {16'h0000, outMap_q};
      `ICEDBG_BP0_OFS:    rd_d = {8'h00, bp0_q};
      `ICEDBG_BP1_OFS:    rd_d = {8'h00, bp1_q};
      `ICEDBG_CYC_OFS:    rd_d = cycCnt_q; // R8
      `ICEDBG_TRIDX_OFS:  rd_d = {26'h000_0000, trIdx_q};
      `ICEDBG_TRADDR_OFS: rd_d = (trIdx_q < fill_q) ? {16'h0000, trAddr_q[rdSlot]} :
                                 32'h0000_0000; // R7
      `ICEDBG_TRDATA_OFS: rd_d = (trIdx_q < fill_q) ? {16'h0000, trDs_q[rdSlot]} :
                                 32'h0000_0000; // R7
      `ICEDBG_IRQST_OFS:  rd_d = {28'h000_0000, irqSt_q};
      `ICEDBG_IRQEN_OFS:  rd_d = {28'h000_0000, irqEn_q};
      `ICEDBG_IRQCLR_OFS: rd_d = 32'h0000_0000;
      `ICEDBG_CFG_OFS:    rd_d = {31'h0000_0000, useUserClk_q};
      default:            rdOk = 1'b0;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'b00;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd_d;
      rresp  <= rdOk ? 2'b00 : 2'b10;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

//--- rtl/icedbg_regs.vh
`ifndef ICEDBG_REGS_VH
`define ICEDBG_REGS_VH
// How it works
// R1 - Host memory overlays target in 4K segments
// R2 - Host ports overlay target in 16-port groups
// R3 - Host-owned regions are served by host
// R4 - Two breakpoints on mem/io read/write cycles
// R5 - Breakpoints optionally ANDed with stack/fetch/user
// R6 - Breakpoint hit stops emulation, enters interrogation
// R7 - Trace address, data, status of 44 cycles
// R8 - Count clock cycles since program start
// R9 - Multi-step stores status each cycle, continues
// R10 - Multi-step ends on breakpoint or command
// R11 - Clock from 2 MHz crystal or user clock
// R12 - Each breakpoint holds a 24-bit value
// R13 - 8-bit command and status registers
// R14 - Trace is circular and freezes on halt
// R15 - Cycle counter clears on start, holds halted
`define ICEDBG_CMD_OFS      8'h00
`define ICEDBG_STAT_OFS     8'h04
`define ICEDBG_MEMMAP_OFS   8'h08
`define ICEDBG_INMAP_OFS    8'h0c
`define ICEDBG_OUTMAP_OFS   8'h10
`define ICEDBG_BP0_OFS      8'h14
`define ICEDBG_BP1_OFS      8'h18
`define ICEDBG_CYC_OFS      8'h1c
`define ICEDBG_TRIDX_OFS    8'h20
`define ICEDBG_TRADDR_OFS   8'h24
`define ICEDBG_TRDATA_OFS   8'h28
`define ICEDBG_IRQST_OFS    8'h2c
`define ICEDBG_IRQEN_OFS    8'h30
`define ICEDBG_IRQCLR_OFS   8'h34
`define ICEDBG_CFG_OFS      8'h38
`define ICEDBG_CMD_RUN      8'h01
`define ICEDBG_CMD_STOP     8'h02
`define ICEDBG_CMD_STEP     8'h03
`define ICEDBG_CMD_MSTEP    8'h04
`define ICEDBG_CMD_CONT     8'h05
`define ICEDBG_TRACE_DEPTH  44
`define ICEDBG_SEG_LSB      12
`define ICEDBG_GRP_LSB      4
`define ICEDBG_BP_EN        23
`define ICEDBG_BP_CYC_LSB   16
`define ICEDBG_BP_QUAL_LSB  20
`define ICEDBG_XTAL_HZ      2000000
`define ICEDBG_CLK_HZ       125000000
`endif

//--- rtl/icedbg_bp_cmp.v
`include "icedbg_regs.vh"
module icedbg_bp_cmp (
  input  wire [23:0] bpValue,
  input  wire [15:0] cycAddr,
  input  wire [3:0]  cycKind,
  input  wire        stackOp,
  input  wire        opcodeFetchState,
  input  wire        userProbe,
  output wire        hit
);
  // Bits 15:0 address, 19:16 cycle kinds (mem rd, mem wr, io rd, io wr), 22:20 qualifiers.
  wire [3:0] kindSel;
  wire [2:0] qualSel;
  wire       kindOk;
  wire       qualOk;
  assign kindSel = bpValue[`ICEDBG_BP_CYC_LSB+3:`ICEDBG_BP_CYC_LSB];
  assign qualSel = bpValue[`ICEDBG_BP_QUAL_LSB+2:`ICEDBG_BP_QUAL_LSB];
  assign kindOk  = |(kindSel & cycKind); // R4
  assign qualOk  = (~qualSel[0] | stackOp) & (~qualSel[1] | opcodeFetchState) &
                   (~qualSel[2] | userProbe); // R5
  assign hit     = bpValue[`ICEDBG_BP_EN] & kindOk & qualOk & (bpValue[15:0] == cycAddr); // R12
endmodule

//--- dv/icedbg_core_properties.sv
module icedbg_core_properties (
  input wire        clk,
  input wire        rst,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready,
  input wire        xtalClkTick,
  input wire        userClkTick,
  input wire        emuRun,
  input wire        emuClkTick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_wr_busy; awvalid && awready |=> !awready; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write address taken twice");
  property p_w_busy; wvalid && wready |=> !wready; endproperty
  a_w_busy: assert property (p_w_busy) else $error("write data taken twice");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_busy; rvalid && rready |=> !rvalid; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read answer not released");
  property p_rd_ans; arvalid && arready |=> rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_wr_ans; awvalid && awready && wvalid && wready |-> ##[1:2] bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  // Emulation may only start from a host command, never by itself.
  property p_run_cmd; $rose(emuRun) |-> $past(bvalid) or ##[0:1] bvalid; endproperty
  a_run_cmd: assert property (p_run_cmd) else $error("run without command");
  property p_tick_src; emuClkTick |-> xtalClkTick || userClkTick; endproperty
  a_tick_src: assert property (p_tick_src) else $error("tick from nowhere");
  c_halt: cover property ($fell(emuRun));
  c_slverr: cover property (bvalid && bresp == 2'h2);
  c_user_tick: cover property (emuClkTick && !xtalClkTick);
endmodule

//--- dv/icedbg_target_model.sv
module icedbg_target_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pinOn,
  input  wire logic [15:0] pinAddr,
  input  wire logic [3:0]  pinKind,
  input  wire logic [2:0]  pinQual,
  output logic             cycDone,
  output logic [15:0]      cycAddr,
  output logic [7:0]       cycData,
  output logic [7:0]       cycStatus,
  output logic [3:0]       cycKind,
  output logic             stackOp,
  output logic             opcodeFetchState,
  output logic             userProbe,
  output logic             userClkTick
);
  timeunit 1ns;
  timeprecision 1ps;
  integer      seed = 32'h4aac8fbb;
  logic [31:0] r;
  logic [2:0]  ph;
  // The target keeps cycling while halted, so a trace that does not freeze shows up.
  always @(posedge clk or posedge rst) begin
    ph          <= rst ? 3'h0 : ph + 3'h1;
    cycDone     <= !rst && ph == 3'h6;
    userClkTick <= !rst && ph[1:0] == 2'h1;
    if (rst || ph == 3'h7) begin
      r = $random(seed);
      cycAddr   <= pinOn ? pinAddr : r[15:0];
      cycData   <= pinOn ? pinAddr[7:0] : r[23:16];
      cycStatus <= pinOn ? pinAddr[15:8] : r[31:24];
      cycKind   <= pinOn ? pinKind : 4'h1 << r[1:0];
      {userProbe, opcodeFetchState, stackOp} <= pinOn ? pinQual : r[6:4];
    end
  end
endmodule

//--- dv/icedbg_core_tb.sv
`include "icedbg_regs.vh"
module icedbg_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, t;
  logic [31:0] wdata = 32'h0, v;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        swBreak = 1'b0, xtalClkTick = 1'b0, pinOn = 1'b0;
  logic [15:0] pinAddr = 16'h0;
  logic [3:0]  pinKind = 4'h1, k;
  logic [2:0]  pinQual = 3'h0, q;
  logic [6:0]  xc = 7'h0;
  logic [34:0] expR[$], e;
  logic [1:0]  expB[$];
  logic [21:0] mt[4] = '{{16'h5abc, 4'h1, 2'h2}, {16'h6abc, 4'h2, 2'h0},
                         {16'h3535, 4'h4, 2'h1}, {16'h3535, 4'h8, 2'h0}};
  int          n_mismatch = 0, check_count = 0, i;
  wire [31:0]  rdata;
  wire [15:0]  cycAddr;
  wire [7:0]   cycData, cycStatus;
  wire [3:0]   cycKind;
  wire [1:0]   bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid, cycDone, stackOp, opcodeFetchState;
  wire         userProbe, userClkTick, emuRun, emuClkTick, hostMemSel, hostIoSel, irq;
  icedbg_core DUT (.wstrb(4'hf), .*);
  icedbg_target_model PM (.*);
  always #4 clk = ~clk;
  initial rst <= 1'b1;
  // Two ticks per 125 clocks give 2 MHz without a fractional divider.
  always @(posedge clk) begin
    xc          <= (xc == 7'h7c) ? 7'h0 : xc + 7'h1;
    xtalClkTick <= xc == 7'h0 || xc == 7'h3e;
  end
  task automatic chk(input string n, input logic [33:0] x, input logic [33:0] g);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    expB.push_back(r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [34:0] x, output logic [31:0] d);
    expR.push_back(x);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
  endtask
  task automatic halt_wait;
    repeat (60) if (emuRun) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rvalid && rready) begin
      e = expR.pop_front();
      if (e[34]) chk("rdata", e[33:0], {rresp, rdata});
    end
    if (bvalid && bready) chk("bresp", expB.pop_front(), bresp);
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`ICEDBG_IRQEN_OFS, 35'h400000000, v);
    rd(8'h3c, 35'h600000000, v);
    wr(8'h3c, 32'h1, 2'h2);
    $display("test registers done");
    wr(`ICEDBG_MEMMAP_OFS, 32'h20, 2'h0);
    wr(`ICEDBG_INMAP_OFS, 32'h8, 2'h0);
    pinOn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      pinAddr <= mt[i][21:6];
      pinKind <= mt[i][5:2];
      repeat (10) @(posedge clk);
      chk("hostSel", mt[i][1:0], {hostMemSel, hostIoSel});
    end
    $display("test maps done");
    for (i = 0; i < 4; i++) begin
      t = 8'h8 << i;
      q = t[6:4];
      k = 4'h1 << i;
      wr(i[0] ? `ICEDBG_BP1_OFS : `ICEDBG_BP0_OFS, {8'h0, 1'b1, q, k, 16'h1230 + 16'(i)}, 2'h0);
      wr(`ICEDBG_IRQEN_OFS, 32'h1 << i[0], 2'h0);
      pinOn   <= 1'b1;
      pinAddr <= 16'h1230 + 16'(i);
      pinKind <= (q != 3'h0) ? k : {k[2:0], k[3]};
      pinQual <= 3'h0;
      wr(`ICEDBG_CMD_OFS, `ICEDBG_CMD_RUN, 2'h0);
      repeat (70) @(posedge clk);
      chk("emuRun", 1'b1, emuRun);
      pinKind <= k;
      pinQual <= q;
      halt_wait();
      pinOn <= 1'b0;
      chk("emuRun", 1'b0, emuRun);
      chk("irq", 1'b1, irq);
      rd(`ICEDBG_IRQST_OFS, {3'h4, 32'h1 << i[0]}, v);
      rd(`ICEDBG_STAT_OFS, {3'h4, 32'h20 << i[0]}, v);
      wr(`ICEDBG_TRIDX_OFS, 32'h0, 2'h0);
      rd(`ICEDBG_TRADDR_OFS, {19'h40000, 16'h1230 + 16'(i)}, v);
      rd(`ICEDBG_TRDATA_OFS, {19'h40000, 16'h1230 + 16'(i)}, v);
      wr(`ICEDBG_IRQCLR_OFS, 32'h3, 2'h0);
      @(posedge clk);
      chk("irq", 1'b0, irq);
    end
    rd(`ICEDBG_CYC_OFS, 35'h0, v);
    chk("cycNonzero", 1'b1, v != 32'h0);
    rd(`ICEDBG_CYC_OFS, {3'h4, v}, v);
    $display("test breakpoints done");
    wr(`ICEDBG_CMD_OFS, `ICEDBG_CMD_STEP, 2'h0);
    halt_wait();
    chk("irq", 1'b0, irq);
    rd(`ICEDBG_IRQST_OFS, 35'h400000004, v);
    wr(`ICEDBG_IRQCLR_OFS, 32'hf, 2'h0);
    wr(`ICEDBG_CMD_OFS, `ICEDBG_CMD_MSTEP, 2'h0);
    repeat (60) @(posedge clk);
    chk("emuRun", 1'b1, emuRun);
    swBreak <= 1'b1;
    @(posedge clk);
    swBreak <= 1'b0;
    halt_wait();
    chk("emuRun", 1'b0, emuRun);
    rd(`ICEDBG_IRQST_OFS, 35'h400000008, v);
    wr(`ICEDBG_CMD_OFS, `ICEDBG_CMD_CONT, 2'h0);
    chk("emuRun", 1'b1, emuRun);
    wr(`ICEDBG_CMD_OFS, `ICEDBG_CMD_STOP, 2'h0);
    chk("emuRun", 1'b0, emuRun);
    wr(`ICEDBG_CMD_OFS, `ICEDBG_CMD_MSTEP, 2'h0);
    chk("emuRun", 1'b1, emuRun);
    wr(`ICEDBG_CMD_OFS, `ICEDBG_CMD_STOP, 2'h0);
    chk("emuRun", 1'b0, emuRun);
    for (i = 1; i >= 0; i--) begin
      wr(`ICEDBG_CFG_OFS, 32'(i), 2'h0);
      repeat (20) begin
        @(posedge clk);
        chk("emuClkTick", i[0] ? userClkTick : xtalClkTick, emuClkTick);
      end
    end
    $display("test stepping and clock done");
    report_and_stop();
  end
endmodule
bind icedbg_core icedbg_core_properties u_props (.*);
